// >>> common/jtidr_defines.svh
// jtidr_defines.svh: offsets, codes, field positions and counts of the
// test access port instruction decode and identification register.
// assumes: included by bare name from the package and the design file.
`ifndef JTIDR_DEFINES_SVH
`define JTIDR_DEFINES_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JT_IR_W        8
`define JT_OP_EXTEST   8'h00
`define JT_OP_IDCODE   8'h21
`define JT_OP_SAMPLE   8'h05
`define JT_OP_CLAMP    8'h07
`define JT_OP_HIGHZ    8'h03
`define JT_OP_BYPASS   8'hFF
`define JT_IR_CAPT     8'h01

// ----------------------------------------------------------------------
// identification word layout
// ----------------------------------------------------------------------
`define JT_ID_W        32
`define JT_ID_REV_MSB  31
`define JT_ID_REV_LSB  28
`define JT_ID_DEV_MSB  27
`define JT_ID_DEV_LSB  12
`define JT_ID_MFR_MSB  11
`define JT_ID_MFR_LSB  1
`define JT_ID_PRESENT  1'b1

// ----------------------------------------------------------------------
// sizes and the bypass capture value
// ----------------------------------------------------------------------
`define JT_BSR_LEN     121
`define JT_BSR_OUTS    40
`define JT_FIFO_DEPTH  4
`define JT_BYP_CAPT    1'b0

`endif

// >>> common/jtidr_pkg.sv
// jtidr_pkg: types of the scan port design; the bench does not use them.
// assumes: jtidr_defines.svh is on the include path.
`include "jtidr_defines.svh"

package jtidr_pkg;

  // ----------------------------------------------------------------------
  // tap controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PA_DR  = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UP_DR  = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC,
    TAP_PA_IR  = 4'hD,
    TAP_EX2_IR = 4'hE,
    TAP_UP_IR  = 4'hF
  } jtidr_tap_t;

  // ----------------------------------------------------------------------
  // link pins, carried together through the synchroniser
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtidr_link_t;

endpackage : jtidr_pkg

// >>> rtl/jtidr_top.sv
// jtidr_top: scan port of a memory device: tap controller, instruction
// decode, bypass, identification and boundary registers, pad control.
// assumes: one system clock much faster than the test clock; test clock,
// mode select and data in arrive from a board-level scan controller.
`timescale 1ns/1ps
`include "jtidr_defines.svh"

// ----------------------------------------------------------------------
// small fifo, one word per push, valid and ready on both sides
// ----------------------------------------------------------------------
module jtidr_fifo #(
  parameter int W = 1,
  parameter int D = `JT_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } jtidr_fifo_st_t;

  jtidr_fifo_st_t s_r;
  jtidr_fifo_st_t s_nxt;
  logic           push;
  logic           pop;

  // full and empty come straight from the fill count
  assign in_ready  = (s_r.cnt != (AW+1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers wrap at depth, so any depth works, not only powers of two
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
    if (push && !pop) s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop && !push) s_nxt.cnt = s_r.cnt - 1'b1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : jtidr_fifo

module jtidr_top #(
  parameter int          BSR_LEN = `JT_BSR_LEN,
  parameter int          NO      = `JT_BSR_OUTS,
  parameter logic [3:0]  ID_REV  = 4'h1,     // arbitrary value
  parameter logic [15:0] ID_DEV  = 16'h1234, // arbitrary value
  parameter logic [10:0] ID_MFR  = 11'h055   // arbitrary value
) (
  input  wire logic            SYS_CLK,
  input  wire logic            RST_B,
  input  wire logic            TCK,
  input  wire logic            TMS,
  input  wire logic            TDI,
  output logic                 TDO,
  output logic                 TDO_OE_B,
  input  wire logic [BSR_LEN-NO-1:0] PIN_IN,
  input  wire logic [NO-1:0]   CORE_OUT,
  input  wire logic [NO-1:0]   CORE_OE_B,
  output logic [NO-1:0]        PAD_OUT,
  output logic [NO-1:0]        PAD_OE_B,
  output logic [`JT_IR_W-1:0]  IR_CUR
);
  localparam int NI = BSR_LEN - NO;

  // ----------------------------------------------------------------------
  // state of the whole port
  // ----------------------------------------------------------------------
  typedef struct packed {
    jtidr_pkg::jtidr_link_t lk1;   // first synchroniser stage
    jtidr_pkg::jtidr_link_t lk2;   // second synchroniser stage
    logic                   tck_d; // previous synchronised test clock
    logic [NI-1:0]          pin1;
    logic [NI-1:0]          pin2;
    logic                   pend;  // rising edge waiting for fifo room
    jtidr_pkg::jtidr_tap_t  tap;
    logic [`JT_IR_W-1:0]    ir;
    logic [`JT_IR_W-1:0]    ir_sr;
    logic                   byp;
    logic [`JT_ID_W-1:0]    id_sr;
    logic [BSR_LEN-1:0]     bsr;
    logic [NO-1:0]          upd;   // boundary output latches
    logic                   tdo;
    logic                   tdo_oe_b;
    logic [NO-1:0]          pad_out;
    logic [NO-1:0]          pad_oe_b;
  } jtidr_st_t;

  jtidr_st_t s_r;
  jtidr_st_t s_nxt;

  logic rise;
  logic fall;
  logic go;
  logic sel_bsr;
  logic sel_id;
  logic drive_bsr;
  logic push;
  logic push_bit;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_bit;
  logic pop;

  // ----------------------------------------------------------------------
  // hard-wired identification word
  // ----------------------------------------------------------------------
  localparam logic [`JT_ID_W-1:0] ID_WORD =
    {ID_REV, ID_DEV, ID_MFR, `JT_ID_PRESENT};

  // ----------------------------------------------------------------------
  // edge detection on the synchronised test clock
  // ----------------------------------------------------------------------
  // both edges are seen two system clocks late; mode and data are delayed
  // by the same stages, so they stay aligned with the clock edges
  assign rise = s_r.lk2.tck & ~s_r.tck_d;
  assign fall = ~s_r.lk2.tck & s_r.tck_d;
  // an edge held back by a full fifo is replayed, never dropped
  assign go   = (rise | s_r.pend) & fifo_ready;

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  // only extest and sample use the boundary register, only idcode the id
  // register; clamp, highz, bypass and every reserved code get the bypass
  always_comb begin
    sel_bsr   = 1'b0;
    sel_id    = 1'b0;
    drive_bsr = 1'b0;
    if (s_r.ir == `JT_OP_EXTEST) begin
      sel_bsr   = 1'b1;
      drive_bsr = 1'b1;
    end else if (s_r.ir == `JT_OP_SAMPLE) begin
      sel_bsr   = 1'b1;
    end else if (s_r.ir == `JT_OP_IDCODE) begin
      sel_id    = 1'b1;
    end else if (s_r.ir == `JT_OP_CLAMP) begin
      drive_bsr = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // tap controller next state
  // ----------------------------------------------------------------------
  function automatic jtidr_pkg::jtidr_tap_t tap_next(
    input jtidr_pkg::jtidr_tap_t st,
    input logic                  tms
  );
    jtidr_pkg::jtidr_tap_t n;
    n = st;
    case (st)
      jtidr_pkg::TAP_RESET:
        n = tms ? jtidr_pkg::TAP_RESET  : jtidr_pkg::TAP_IDLE;
      jtidr_pkg::TAP_IDLE:
        n = tms ? jtidr_pkg::TAP_SEL_DR : jtidr_pkg::TAP_IDLE;
      jtidr_pkg::TAP_SEL_DR:
        n = tms ? jtidr_pkg::TAP_SEL_IR : jtidr_pkg::TAP_CAP_DR;
      jtidr_pkg::TAP_CAP_DR:
        n = tms ? jtidr_pkg::TAP_EX1_DR : jtidr_pkg::TAP_SH_DR;
      jtidr_pkg::TAP_SH_DR:
        n = tms ? jtidr_pkg::TAP_EX1_DR : jtidr_pkg::TAP_SH_DR;
      jtidr_pkg::TAP_EX1_DR:
        n = tms ? jtidr_pkg::TAP_UP_DR  : jtidr_pkg::TAP_PA_DR;
      jtidr_pkg::TAP_PA_DR:
        n = tms ? jtidr_pkg::TAP_EX2_DR : jtidr_pkg::TAP_PA_DR;
      jtidr_pkg::TAP_EX2_DR:
        n = tms ? jtidr_pkg::TAP_UP_DR  : jtidr_pkg::TAP_SH_DR;
      jtidr_pkg::TAP_UP_DR:
        n = tms ? jtidr_pkg::TAP_SEL_DR : jtidr_pkg::TAP_IDLE;
      jtidr_pkg::TAP_SEL_IR:
        n = tms ? jtidr_pkg::TAP_RESET  : jtidr_pkg::TAP_CAP_IR;
      jtidr_pkg::TAP_CAP_IR:
        n = tms ? jtidr_pkg::TAP_EX1_IR : jtidr_pkg::TAP_SH_IR;
      jtidr_pkg::TAP_SH_IR:
        n = tms ? jtidr_pkg::TAP_EX1_IR : jtidr_pkg::TAP_SH_IR;
      jtidr_pkg::TAP_EX1_IR:
        n = tms ? jtidr_pkg::TAP_UP_IR  : jtidr_pkg::TAP_PA_IR;
      jtidr_pkg::TAP_PA_IR:
        n = tms ? jtidr_pkg::TAP_EX2_IR : jtidr_pkg::TAP_PA_IR;
      jtidr_pkg::TAP_EX2_IR:
        n = tms ? jtidr_pkg::TAP_UP_IR  : jtidr_pkg::TAP_SH_IR;
      jtidr_pkg::TAP_UP_IR:
        n = tms ? jtidr_pkg::TAP_SEL_DR : jtidr_pkg::TAP_IDLE;
      default: n = jtidr_pkg::TAP_RESET;
    endcase
    return n;
  endfunction : tap_next

  // ----------------------------------------------------------------------
  // next state of the port
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    push        = 1'b0;
    push_bit    = 1'b0;
    pop         = 1'b0;
    // synchronisers: stage one feeds stage two and nothing else
    s_nxt.lk1   = '{tck: TCK, tms: TMS, tdi: TDI};
    s_nxt.lk2   = s_r.lk1;
    s_nxt.tck_d = s_r.lk2.tck;
    // pin values may move during capture; the synchroniser keeps them
    // clean but cannot make such a sample repeatable
    s_nxt.pin1  = PIN_IN;
    s_nxt.pin2  = s_r.pin1;
    s_nxt.pend  = (rise | s_r.pend) & ~fifo_ready;

    // rising test clock: register actions of the current state
    if (go) begin
      case (s_r.tap)
        jtidr_pkg::TAP_CAP_DR: begin
          if (sel_bsr) begin
            s_nxt.bsr = {s_r.pin2, s_r.pad_out};
          end else if (sel_id) begin
            s_nxt.id_sr = ID_WORD;
          end else begin
            s_nxt.byp = `JT_BYP_CAPT;
          end
        end
        jtidr_pkg::TAP_SH_DR: begin
          if (sel_bsr) begin
            s_nxt.bsr = {s_r.lk2.tdi, s_r.bsr[BSR_LEN-1:1]};
          end else if (sel_id) begin
            s_nxt.id_sr = {s_r.lk2.tdi, s_r.id_sr[`JT_ID_W-1:1]};
          end else begin
            s_nxt.byp = s_r.lk2.tdi;
          end
        end
        jtidr_pkg::TAP_UP_DR: if (sel_bsr) s_nxt.upd = s_r.bsr[NO-1:0];
        jtidr_pkg::TAP_CAP_IR: s_nxt.ir_sr = `JT_IR_CAPT;
        jtidr_pkg::TAP_SH_IR: begin
          s_nxt.ir_sr = {s_r.lk2.tdi, s_r.ir_sr[`JT_IR_W-1:1]};
        end
        jtidr_pkg::TAP_UP_IR: s_nxt.ir = s_r.ir_sr;
        default: s_nxt.ir = s_r.ir;
      endcase
      s_nxt.tap = tap_next(s_r.tap, s_r.lk2.tms);
      // idcode is loaded on the very rise that enters or holds reset
      if (s_nxt.tap == jtidr_pkg::TAP_RESET) s_nxt.ir = `JT_OP_IDCODE;

      // queue the bit that sits at the outgoing end after this edge
      if (s_nxt.tap == jtidr_pkg::TAP_SH_IR) begin
        push     = 1'b1;
        push_bit = s_nxt.ir_sr[0];
      end else if (s_nxt.tap == jtidr_pkg::TAP_SH_DR) begin
        push     = 1'b1;
        push_bit = sel_bsr ? s_nxt.bsr[0]
                 : (sel_id ? s_nxt.id_sr[0] : s_nxt.byp);
      end
    end

    // falling test clock: serial out is driven only in the shift states
    if (fall) begin
      if (s_r.tap == jtidr_pkg::TAP_SH_IR ||
          s_r.tap == jtidr_pkg::TAP_SH_DR) begin
        pop = 1'b1;
        if (fifo_valid) s_nxt.tdo = fifo_bit;
        s_nxt.tdo_oe_b = 1'b0;
      end else begin
        s_nxt.tdo_oe_b = 1'b1;
      end
    end

    // pads follow the current instruction, not the one being shifted
    if (s_r.ir == `JT_OP_HIGHZ) begin
      s_nxt.pad_out  = CORE_OUT;
      s_nxt.pad_oe_b = '1;
    end else if (drive_bsr) begin
      s_nxt.pad_out  = s_r.upd;
      s_nxt.pad_oe_b = '0;
    end else begin
      s_nxt.pad_out  = CORE_OUT;
      s_nxt.pad_oe_b = CORE_OE_B;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // power-up puts the tap in reset with idcode loaded and serial out off
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r          <= '0;
      s_r.tap      <= jtidr_pkg::TAP_RESET;
      s_r.ir       <= `JT_OP_IDCODE;
      s_r.tdo_oe_b <= 1'b1;
      s_r.pad_oe_b <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // serial out queue
  // ----------------------------------------------------------------------
  // decouples the shift on the rising edge from the drive on the falling
  // edge; it holds one bit in normal use, a full queue stalls the tap
  jtidr_fifo #(
    .W (1),
    .D (`JT_FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_bit),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_bit)
  );

  // outputs straight from the state register
  assign TDO      = s_r.tdo;
  assign TDO_OE_B = s_r.tdo_oe_b;
  assign PAD_OUT  = s_r.pad_out;
  assign PAD_OE_B = s_r.pad_oe_b;
  assign IR_CUR   = s_r.ir;
endmodule : jtidr_top

// >>> tb/jtidr_top_monitor.sv
// jtidr_top_monitor: pin-level timing and pad checks of the scan port.
// assumes: bound into jtidr_top; TCK is far slower than SYS_CLK.
`timescale 1ns/1ps
`include "jtidr_defines.svh"
module jtidr_top_monitor #(
  parameter int BSR_LEN = `JT_BSR_LEN,
  parameter int NO      = `JT_BSR_OUTS
) (
  input wire logic                  SYS_CLK,
  input wire logic                  RST_B,
  input wire logic                  TCK,
  input wire logic                  TMS,
  input wire logic                  TDI,
  input wire logic                  TDO,
  input wire logic                  TDO_OE_B,
  input wire logic [BSR_LEN-NO-1:0] PIN_IN,
  input wire logic [NO-1:0]         CORE_OUT,
  input wire logic [NO-1:0]         CORE_OE_B,
  input wire logic [NO-1:0]         PAD_OUT,
  input wire logic [NO-1:0]         PAD_OE_B,
  input wire logic [`JT_IR_W-1:0]   IR_CUR
);
  // ------------------------------------------------------------------
  // ages of the last test clock edges, seen straight at the pin
  // ------------------------------------------------------------------
  logic       tck_d_r;
  logic [3:0] rise_age_r;
  logic [3:0] fall_age_r;
  logic [2:0] hi_cnt_r;

  // ages saturate so a parked clock never fakes a fresh edge
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tck_d_r    <= 1'b0;
      rise_age_r <= 4'hF;
      fall_age_r <= 4'hF;
      hi_cnt_r   <= 3'h0;
    end else begin
      tck_d_r <= TCK;
      if (TCK && !tck_d_r) rise_age_r <= 4'h0;
      else if (rise_age_r != 4'hF) rise_age_r <= rise_age_r + 4'h1;
      if (!TCK && tck_d_r) fall_age_r <= 4'h0;
      else if (fall_age_r != 4'hF) fall_age_r <= fall_age_r + 4'h1;
      if (TCK && !tck_d_r && !TMS) hi_cnt_r <= 3'h0;
      else if (TCK && !tck_d_r && hi_cnt_r != 3'h7)
        hi_cnt_r <= hi_cnt_r + 3'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_tdo_on_fall: assert property (
    $changed(TDO) |-> fall_age_r inside {[4'h1:4'h5]})
    else $error("TDO moved away from a test clock fall");
  a_oe_on_fall: assert property (
    $fell(TDO_OE_B) |-> fall_age_r <= 4'h5 ##1 !TDO_OE_B [*3])
    else $error("TDO drive started off a fall or dropped early");
  a_ir_on_rise: assert property (
    $changed(IR_CUR) |-> rise_age_r <= 4'h7)
    else $error("instruction changed away from a test clock rise");
  a_ir_tlr_reset: assert property (
    hi_cnt_r >= 3'h5 && rise_age_r == 4'h7 |-> IR_CUR == `JT_OP_IDCODE)
    else $error("five high mode rises left a non-id instruction");
  a_highz_float: assert property (
    $past(IR_CUR) == `JT_OP_HIGHZ |-> &PAD_OE_B)
    else $error("a pad drives under the float instruction");
  a_extest_drive: assert property (
    $past(IR_CUR) == `JT_OP_EXTEST |-> PAD_OE_B == '0)
    else $error("a pad is not driven under external test");
  a_clamp_hold: assert property (
    $past(IR_CUR, 2) == `JT_OP_CLAMP && $past(IR_CUR) == `JT_OP_CLAMP
    |-> PAD_OE_B == '0 && $stable(PAD_OUT))
    else $error("clamped pads moved or floated");
  a_normal_pass: assert property (
    $past(RST_B) && !($past(IR_CUR) inside {`JT_OP_EXTEST,
      `JT_OP_CLAMP, `JT_OP_HIGHZ})
    |-> PAD_OUT == $past(CORE_OUT) && PAD_OE_B == $past(CORE_OE_B))
    else $error("pads left normal operation");
  a_latch_update: assert property (
    $past(IR_CUR, 2) == `JT_OP_EXTEST && $past(IR_CUR) == `JT_OP_EXTEST
    && $changed(PAD_OUT) |-> rise_age_r <= 4'h7)
    else $error("test pads changed away from an update");
endmodule : jtidr_top_monitor

bind jtidr_top jtidr_top_monitor #(.BSR_LEN(BSR_LEN), .NO(NO))
  jtidr_top_monitor_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .TCK(TCK),
  .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE_B(TDO_OE_B), .PIN_IN(PIN_IN),
  .CORE_OUT(CORE_OUT), .CORE_OE_B(CORE_OE_B), .PAD_OUT(PAD_OUT),
  .PAD_OE_B(PAD_OE_B), .IR_CUR(IR_CUR));

// >>> tb/jtidr_ctl_model.sv
// jtidr_ctl_model: board scan controller that walks the tap and shifts.
// assumes: sys_clk of 100 ns; its tasks are called from the bench top.
`timescale 1ns/1ps
module jtidr_ctl_model (
  input  wire logic   sys_clk,
  input  wire logic   tdo,
  input  wire logic   tdo_oe_b,
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  output logic        res_valid,
  output logic [63:0] res_data
);
  // ------------------------------------------------------------------
  // one test clock: 400 ns low, 400 ns high, then it stands high
  // ------------------------------------------------------------------
  initial begin
    tck       = 1'b0;
    tms       = 1'b1;
    tdi       = 1'b0;
    res_valid = 1'b0;
    res_data  = '0;
  end

  // mode and data move with the fall, far from the rise that samples
  // them; an undriven TDO reads inverted so a lost drive cannot pass
  task automatic step(input logic ms, input logic di, output logic so);
    @(negedge sys_clk);
    tck = 1'b0;
    tms = ms;
    tdi = di;
    repeat (4) @(negedge sys_clk);
    tck = 1'b1;
    repeat (2) @(negedge sys_clk);
    so = tdo_oe_b ? ~tdo : tdo;
    @(negedge sys_clk);
  endtask : step

  // idle to idle scan of n bits, LSB first; idle TDI toggles each step
  task automatic scan(input logic ir, input int n, input logic [63:0] din);
    logic [63:0] q;
    logic        b;
    q = '0;
    step(1'b1, ~tdi, b);
    if (ir) step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
    step(1'b0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      q[i] = b;
    end
    step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
    res_data  = q;
    res_valid = 1'b1;
    @(negedge sys_clk);
    res_valid = 1'b0;
  endtask : scan

  // five high mode rises, then settle in idle
  task automatic tap_reset();
    logic b;
    repeat (5) step(1'b1, ~tdi, b);
    step(1'b0, ~tdi, b);
  endtask : tap_reset
endmodule : jtidr_ctl_model

// >>> tb/tb.sv
// tb: scan port words, instructions and pads, through the serial out queue.
// assumes: package, design and monitor files compiled before this one.
`timescale 1ns/1ps
`include "jtidr_defines.svh"
module tb;
  localparam int          BL  = 24;
  localparam int          NOC = 8;
  localparam logic [3:0]  REV = 4'h6;     // arbitrary value
  localparam logic [15:0] DEV = 16'hA5C3; // arbitrary value
  localparam logic [10:0] MFR = 11'h2B4;  // arbitrary value
  localparam logic [31:0] IDW = {REV, DEV, MFR, 1'b1};

  logic              sys_clk   = 1'b0;
  logic              rst_b     = 1'b0;
  logic              tck, tms, tdi, tdo, tdo_oe_b, res_valid;
  logic [BL-NOC-1:0] pin_in    = '0;
  logic [NOC-1:0]    core_out  = '0;
  logic [NOC-1:0]    core_oe_b = '0;
  logic [NOC-1:0]    pad_out, pad_oe_b;
  logic [7:0]        ir_cur;
  logic [63:0]       res_data;
  logic              hold      = 1'b0;
  int                seed      = 32'h7dd507d0;
  int                err_total = 0;
  int                checked   = 0;
  int                cycles    = 0;
  logic [63:0]       exp_q[$];

  always #50 sys_clk = ~sys_clk;

  jtidr_top #(.BSR_LEN(BL), .NO(NOC), .ID_REV(REV), .ID_DEV(DEV),
    .ID_MFR(MFR)) jtidr_top_i (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE_B(tdo_oe_b),
    .PIN_IN(pin_in), .CORE_OUT(core_out), .CORE_OE_B(core_oe_b),
    .PAD_OUT(pad_out), .PAD_OE_B(pad_oe_b), .IR_CUR(ir_cur));
  jtidr_ctl_model jtidr_ctl_model_i (.sys_clk(sys_clk), .tdo(tdo),
    .tdo_oe_b(tdo_oe_b), .tck(tck), .tms(tms), .tdi(tdi),
    .res_valid(res_valid), .res_data(res_data));

  // ------------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------------
  task automatic expect_eq(input logic [63:0] got, input logic [63:0] want);
    checked++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : expect_eq

  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ceiling about four times the planned walk
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
    end
  end

  // oldest noted word against each returned word; a stray word is a miss
  always @(posedge sys_clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        expect_eq(res_data, exp_q.pop_front());
      end else begin
        err_total++;
        $display("unexpected at %0t: word with nothing noted", $time);
      end
    end
  end

  // pins wander each cycle except while a capture must see them still
  always @(negedge sys_clk) begin
    if (!hold) begin
      pin_in    <= (BL-NOC)'($random(seed));
      core_out  <= NOC'($random(seed));
      core_oe_b <= NOC'($random(seed));
    end
  end

  // ------------------------------------------------------------------
  // scan helpers
  // ------------------------------------------------------------------
  task automatic load_ir(input logic [7:0] code);
    exp_q.push_back({56'h0, `JT_IR_CAPT});
    jtidr_ctl_model_i.scan(1'b1, 8, {56'h0, code});
    expect_eq({56'h0, ir_cur}, {56'h0, code});
  endtask : load_ir

  task automatic dr(input int n, input logic [63:0] din,
                    input logic [63:0] want);
    exp_q.push_back(want);
    jtidr_ctl_model_i.scan(1'b0, n, din);
  endtask : dr

  initial begin
    logic [63:0] v;
    logic [63:0] w;
    logic [63:0] d;
    logic [7:0]  codes [4];
    codes = '{`JT_OP_CLAMP, `JT_OP_HIGHZ, 8'h5A, `JT_OP_BYPASS};
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    jtidr_ctl_model_i.tap_reset();
    expect_eq({56'h0, ir_cur}, {56'h0, `JT_OP_IDCODE});
    dr(32, {$random(seed), $random(seed)}, {32'h0, IDW});
    // snapshot with pins held, preloading the first test vector
    load_ir(`JT_OP_SAMPLE);
    // the core output byte is held with the rest, so no bit needs masking
    hold = 1'b1;
    v = {$random(seed), $random(seed)};
    @(negedge sys_clk);
    dr(BL, v, {40'h0, pin_in, core_out});
    load_ir(`JT_OP_EXTEST);
    expect_eq({48'h0, pad_oe_b, pad_out}, {48'h0, 8'h00, v[7:0]});
    w = {$random(seed), $random(seed)};
    dr(BL, w, {40'h0, pin_in, v[7:0]});
    expect_eq({56'h0, pad_out}, {56'h0, w[7:0]});
    hold = 1'b0;
    // one-bit path codes, a reserved one among them
    for (int i = 0; i < 4; i++) begin
      load_ir(codes[i]);
      d = {56'h0, 8'($random(seed))};
      dr(8, d, {55'h0, d[6:0], 1'b0});
      if (codes[i] == `JT_OP_CLAMP)
        expect_eq({48'h0, pad_oe_b, pad_out}, {48'h0, 8'h00, w[7:0]});
      if (codes[i] == `JT_OP_HIGHZ)
        expect_eq({56'h0, pad_oe_b}, {56'h0, 8'hFF});
    end
    jtidr_ctl_model_i.tap_reset();
    expect_eq({56'h0, ir_cur}, {56'h0, `JT_OP_IDCODE});
    load_ir(`JT_OP_IDCODE);
    dr(32, '0, {32'h0, IDW});
    // a scan longer than the id word streams the first bits in back out
    d = {$random(seed), $random(seed)};
    dr(40, d, {24'h0, d[7:0], IDW});
    expect_eq({63'h0, tdo_oe_b}, 64'h1);
    expect_eq(64'(exp_q.size()), 64'h0);
    test_done();
  end
endmodule : tb
